// ===== hdl/fpec_blk_decode.sv
// maps a flash address onto its erase block and checks unit alignment
`timescale 1ns/1ns
`default_nettype none
module fpec_blk_decode
    import fpec_pkg::*;
(
    input wire logic [14:0] addr,
    output logic [4:0] blk_onehot,
    output logic unit_aligned
);
    always_comb begin
        blk_onehot = FPEC_BLK_RST;
        if (addr < FPEC_SMALL_END) begin
            blk_onehot[addr[FPEC_SMALL_SH+1:FPEC_SMALL_SH]] = 1'b1; // RQ2
        end else begin
            blk_onehot[FPEC_NBLK-1] = 1'b1; // RQ2
        end
        unit_aligned = (addr[6:0] == FPEC_UNIT_OFS); // RQ1
    end
endmodule
`default_nettype wire

// ===== hdl/fpec_ctrl.sv
// flash program/erase control registers and mode sequencer
// Function
// RQ1 - program in 128-byte units starting at low byte 00 or 80
// RQ2 - five erase blocks: four 1-kbyte, one 28-kbyte; erase hits one
// RQ3 - software clears whole array by erasing each block in turn
// RQ4 - write gate bit 6 enables; when 0 other bits and blocks stay 0
// RQ5 - erase-setup bit 5 enters erase setup state; clear cancels
// RQ6 - program-setup bit 4 enters program setup state; clear cancels
// RQ7 - erase-verify bit 3 selects erase-verify mode
// RQ8 - program-verify bit 2 selects program-verify mode
// RQ9 - erase bit 1 enters erase mode only with gate and setup
// RQ10 - program bit 0 enters program mode only with gate and setup
// RQ11 - control register resets to zero; bit 7 reads zero
// RQ12 - failed operation sets fault bit 7 and protects the array
// RQ13 - block select clears when gate is 0 or several bits set
// RQ14 - power-down bit 0 lets subactive mode power down the array; the code allows it while bit 7 is 0
// RQ15 - control registers reachable only while access gate bit 7 set
// RQ16 - no activity when program or erase set without gate or setup
`timescale 1ns/1ns
`default_nettype none
module fpec_ctrl
    import fpec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic subactive,
    input wire logic op_fail,
    output var fpec_array_t array_ctl,
    output logic irq
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic gated_reg;
    logic mapped;
    logic sub_s1_q;
    logic sub_s2_q;
    logic fail_s1_q;
    logic fail_s2_q;
    logic [7:0] mode_q, mode_d;
    logic fault_q, fault_d;
    logic [4:0] blk_q, blk_d;
    logic pwr_q, pwr_d;
    logic gate_q, gate_d;
    logic [1:0] ist_q, ist_d;
    logic [1:0] imask_q, imask_d;
    logic [14:0] tgt_q, tgt_d;
    logic [31:0] rdata_d, rdata_q;
    logic err_d;
    fpec_mode_t st_q, st_d;
    fpec_array_t arr_d;
    logic [4:0] tgt_blk;
    logic tgt_aligned;
    logic busy;
    logic busy_q;

    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign gated_reg = (paddr == FPEC_OFS_MODE) || (paddr == FPEC_OFS_STAT)
        || (paddr == FPEC_OFS_BLK) || (paddr == FPEC_OFS_PWR);
    assign mapped = gated_reg || (paddr == FPEC_OFS_GATE)
        || (paddr == FPEC_OFS_ISTAT) || (paddr == FPEC_OFS_IMASK)
        || (paddr == FPEC_OFS_TARGET);
    // access phase, refused when decode fails or a gated register is hit while the gate is shut
    assign wr_en = psel && penable && pwrite && mapped
        && !(gated_reg && !gate_q); // RQ15
    assign rd_en = psel && !penable && !pwrite;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            fail_s1_q <= 1'b0;
            fail_s2_q <= 1'b0;
        end else begin
            sub_s1_q <= subactive;
            sub_s2_q <= sub_s1_q;
            fail_s1_q <= op_fail;
            fail_s2_q <= fail_s1_q;
        end
    end

    fpec_blk_decode u_dec (
        .addr(tgt_q),
        .blk_onehot(tgt_blk),
        .unit_aligned(tgt_aligned)
    );

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] w;
        w = pwdata[7:0];
        mode_d = mode_q;
        blk_d = blk_q;
        pwr_d = pwr_q;
        gate_d = gate_q;
        imask_d = imask_q;
        tgt_d = tgt_q;
        fault_d = fault_q;
        ist_d = ist_q;
        if (wr_en) begin
            case (paddr)
                FPEC_OFS_MODE: begin
                    mode_d = w & FPEC_MODE_MASK; // RQ11
                    if (!w[FPEC_B_WGATE]) begin
                        mode_d = FPEC_RST8; // RQ4
                    end else if (!mode_q[FPEC_B_WGATE]) begin
                        mode_d = FPEC_RST8; // RQ4
                        mode_d[FPEC_B_WGATE] = 1'b1;
                    end
                end
                FPEC_OFS_BLK: blk_d = w[FPEC_NBLK-1:0];
                FPEC_OFS_PWR: pwr_d = w[FPEC_B_HI];
                FPEC_OFS_GATE: gate_d = w[FPEC_B_HI]; // RQ15
                FPEC_OFS_ISTAT: ist_d = ist_q & ~w[1:0];
                FPEC_OFS_IMASK: imask_d = w[1:0];
                FPEC_OFS_TARGET: tgt_d = pwdata[14:0];
                default: ;
            endcase
        end
        if (!mode_d[FPEC_B_WGATE] || !mode_q[FPEC_B_WGATE]
            || ($countones(blk_d) > 1)) begin
            blk_d = FPEC_BLK_RST; // RQ13
        end
        // fault: a failure during activity, a misaligned program, or an erase whose target lies outside the selected block
        if ((fail_s2_q && busy)
            || (st_q == FPEC_WRITING && !tgt_aligned)
            || (st_q == FPEC_CLEARING && (blk_q != tgt_blk))) begin
            fault_d = 1'b1; // RQ12
            ist_d[FPEC_IRQ_FAULT] = 1'b1;
        end
        // operation completes when its mode bit is dropped
        if (busy_q && !busy) begin
            ist_d[FPEC_IRQ_DONE] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    assign busy = (st_q == FPEC_WRITING) || (st_q == FPEC_CLEARING);

    always_comb begin
        st_d = FPEC_IDLE;
        if (fault_q) begin
            st_d = FPEC_PROTECT; // RQ12
        end else if (mode_q[FPEC_B_WGATE] && mode_q[FPEC_B_CSU]
            && mode_q[FPEC_B_CLR]) begin
            st_d = FPEC_CLEARING; // RQ9
        end else if (mode_q[FPEC_B_WGATE] && mode_q[FPEC_B_WSU]
            && mode_q[FPEC_B_WR]) begin
            st_d = FPEC_WRITING; // RQ10
        end else if (mode_q[FPEC_B_CCHK]) begin
            st_d = FPEC_CLR_CHK; // RQ7
        end else if (mode_q[FPEC_B_WCHK]) begin
            st_d = FPEC_WR_CHK; // RQ8
        end else if (mode_q[FPEC_B_CSU]) begin
            st_d = FPEC_CLR_SETUP; // RQ5
        end else if (mode_q[FPEC_B_WSU]) begin
            st_d = FPEC_WR_SETUP; // RQ6
        end else begin
            st_d = FPEC_IDLE; // RQ16
        end
        arr_d.mode = st_d;
        arr_d.addr = tgt_q;
        arr_d.blocks = (st_d == FPEC_CLEARING) ? blk_q : FPEC_BLK_RST; // RQ2
        arr_d.low_power = sub_s2_q && !pwr_q; // RQ14
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = '0;
        err_d = 1'b0;
        if (rd_en) begin
            if (!mapped || (gated_reg && !gate_q)) begin
                err_d = 1'b1; // RQ15
            end else begin
                case (paddr)
                    FPEC_OFS_MODE: rdata_d[7:0] = mode_q; // RQ11
                    FPEC_OFS_STAT: rdata_d[FPEC_B_HI] = fault_q; // RQ12
                    FPEC_OFS_BLK: rdata_d[FPEC_NBLK-1:0] = blk_q;
                    FPEC_OFS_PWR: rdata_d[FPEC_B_HI] = pwr_q;
                    FPEC_OFS_GATE: rdata_d[FPEC_B_HI] = gate_q;
                    FPEC_OFS_ISTAT: rdata_d[1:0] = ist_q;
                    FPEC_OFS_IMASK: rdata_d[1:0] = imask_q;
                    FPEC_OFS_TARGET: rdata_d[14:0] = tgt_q;
                    default: rdata_d = '0;
                endcase
            end
        end else if (psel && penable) begin
            rdata_d = rdata_q;
            err_d = !mapped || (gated_reg && !gate_q);
        end
    end

    assign pslverr = psel && penable && err_d;

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= FPEC_RST8; // RQ11
            fault_q <= 1'b0;
            blk_q <= FPEC_BLK_RST;
            pwr_q <= 1'b0;
            gate_q <= 1'b0; // RQ15
            ist_q <= FPEC_IRQ_RST;
            imask_q <= FPEC_IRQ_RST;
            tgt_q <= '0;
            rdata_q <= '0;
            st_q <= FPEC_IDLE;
            busy_q <= 1'b0;
            array_ctl <= '0;
            irq <= 1'b0;
        end else begin
            mode_q <= mode_d;
            fault_q <= fault_d;
            blk_q <= blk_d;
            pwr_q <= pwr_d;
            gate_q <= gate_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            tgt_q <= tgt_d;
            rdata_q <= rdata_d;
            st_q <= st_d;
            busy_q <= busy;
            array_ctl <= arr_d;
            irq <= |(ist_d & imask_d);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_prog_armed;
        mode_q[FPEC_B_WGATE] && mode_q[FPEC_B_WSU] && mode_q[FPEC_B_WR]
            && !mode_q[FPEC_B_CLR] && !fault_q;
    endsequence

    sequence s_prog_on;
        st_q == FPEC_WRITING && array_ctl.mode == FPEC_WRITING;
    endsequence

    sequence s_erase_armed;
        mode_q[FPEC_B_WGATE] && mode_q[FPEC_B_CSU] && mode_q[FPEC_B_CLR]
            && !fault_q;
    endsequence

    sequence s_erase_on;
        st_q == FPEC_CLEARING && array_ctl.mode == FPEC_CLEARING;
    endsequence

    AST_PROG_ENTER: assert property ( // RQ10
        @(posedge clk_sys) disable iff (!reset_n)
        s_prog_armed |=> s_prog_on)
        else $error("program mode not entered");
    AST_ERASE_ENTER: assert property ( // RQ9
        @(posedge clk_sys) disable iff (!reset_n)
        s_erase_armed |=> s_erase_on)
        else $error("erase mode not entered");
    AST_NO_ACT: assert property ( // RQ16
        @(posedge clk_sys) disable iff (!reset_n)
        !mode_q[FPEC_B_WGATE] |=> !busy)
        else $error("activity without write gate");
    AST_GATE_OFF: assert property ( // RQ4
        @(posedge clk_sys) disable iff (!reset_n)
        !mode_q[FPEC_B_WGATE] |-> mode_q == FPEC_RST8)
        else $error("control bits set with gate off");
    AST_BLK_CLR: assert property ( // RQ13
        @(posedge clk_sys) disable iff (!reset_n)
        !mode_q[FPEC_B_WGATE] |=> blk_q == FPEC_BLK_RST)
        else $error("block select not cleared");
    AST_BLK_ONE: assert property ( // RQ13
        @(posedge clk_sys) disable iff (!reset_n)
        $countones(blk_q) <= 1)
        else $error("several blocks selected");
    AST_FAULT_STICK: assert property ( // RQ12
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(fault_q) |=> (st_q == FPEC_PROTECT) [*2])
        else $error("fault did not protect array");
    AST_BIT7: assert property ( // RQ11
        @(posedge clk_sys) disable iff (!reset_n)
        !mode_q[FPEC_B_HI])
        else $error("reserved bit set");
    AST_LOWPWR: assert property ( // RQ14
        @(posedge clk_sys) disable iff (!reset_n)
        (sub_s2_q && pwr_q) |=> !array_ctl.low_power)
        else $error("power down while disabled");
    AST_ERASE_ONE: assert property ( // RQ2
        @(posedge clk_sys) disable iff (!reset_n)
        $countones(array_ctl.blocks) <= 1)
        else $error("erase of several blocks");
endmodule
`default_nettype wire

// ===== include/fpec_pkg.sv
// package for the flash program/erase control block
package fpec_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] FPEC_OFS_MODE = 8'h00;
    localparam logic [7:0] FPEC_OFS_STAT = 8'h04;
    localparam logic [7:0] FPEC_OFS_BLK = 8'h08;
    localparam logic [7:0] FPEC_OFS_PWR = 8'h0C;
    localparam logic [7:0] FPEC_OFS_GATE = 8'h10;
    localparam logic [7:0] FPEC_OFS_ISTAT = 8'h14;
    localparam logic [7:0] FPEC_OFS_IMASK = 8'h18;
    localparam logic [7:0] FPEC_OFS_TARGET = 8'h1C;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int FPEC_B_WGATE = 6;
    localparam int FPEC_B_CSU = 5;
    localparam int FPEC_B_WSU = 4;
    localparam int FPEC_B_CCHK = 3;
    localparam int FPEC_B_WCHK = 2;
    localparam int FPEC_B_CLR = 1;
    localparam int FPEC_B_WR = 0;
    localparam int FPEC_B_HI = 7;
    localparam logic [7:0] FPEC_MODE_MASK = 8'h7F;
    localparam logic [7:0] FPEC_RST8 = 8'h00;
    localparam int FPEC_NBLK = 5;
    localparam logic [4:0] FPEC_BLK_RST = 5'h00;
    localparam logic [1:0] FPEC_IRQ_RST = 2'h0;
    localparam int FPEC_IRQ_FAULT = 1;
    localparam int FPEC_IRQ_DONE = 0;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam logic [14:0] FPEC_SMALL_END = 15'h1000;
    localparam logic [6:0] FPEC_UNIT_OFS = 7'h00;
    localparam int FPEC_SMALL_SH = 10;

    // ------------------------------------------------------------
    // array operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FPEC_IDLE = 3'b000,
        FPEC_WR_SETUP = 3'b001,
        FPEC_CLR_SETUP = 3'b010,
        FPEC_WRITING = 3'b011,
        FPEC_CLEARING = 3'b100,
        FPEC_WR_CHK = 3'b101,
        FPEC_CLR_CHK = 3'b110,
        FPEC_PROTECT = 3'b111
    } fpec_mode_t;

    typedef struct packed {
        fpec_mode_t mode;
        logic [14:0] addr;
        logic [4:0] blocks;
        logic low_power;
    } fpec_array_t;

endpackage

// ===== tb/tb.sv
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module tb
    import fpec_pkg::*;
;
    logic clk_sys, reset_n, psel, penable, pwrite, subactive, op_fail;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, irq, err;
    fpec_array_t array_ctl;
    int n_errors, check_count;
    logic [14:0] base [5] = '{15'h0000, 15'h0400, 15'h0800, 15'h0C00, 15'h7F80};

    fpec_ctrl i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .subactive(subactive), .op_fail(op_fail), .array_ctl(array_ctl),
        .irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            tally_and_finish();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e);
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic set_mode(input logic [7:0] v, input fpec_mode_t m);
        wr(FPEC_OFS_MODE, {24'h000000, v});
        settle();
        `CHK(array_ctl.mode, m);
    endtask

    task automatic do_reset;
        reset_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_errors = 0;
        check_count = 0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        subactive = 1'b0;
        op_fail = 1'b0;
        @(posedge clk_sys);
        do_reset();
        `CHK(array_ctl, fpec_array_t'(24'h000000));
        rd(FPEC_OFS_GATE, 32'h0);
        apb(1'b0, FPEC_OFS_MODE, 32'h0);
        `CHK(err, 1'b1);
        wr(FPEC_OFS_MODE, 32'h70);
        `CHK(err, 1'b1);
        wr(FPEC_OFS_GATE, 32'h80);
        rd(FPEC_OFS_GATE, 32'h80);
        rd(FPEC_OFS_MODE, 32'h0);
        rd(8'h20, 32'h0);
        `CHK(err, 1'b1);
        // gate low: nothing sticks; gate high without setup: program or erase bit stays idle
        set_mode(8'h3F, FPEC_IDLE);
        rd(FPEC_OFS_MODE, 32'h0);
        wr(FPEC_OFS_BLK, 32'h1);
        rd(FPEC_OFS_BLK, 32'h0);
        set_mode(8'hC0, FPEC_IDLE);
        rd(FPEC_OFS_MODE, 32'h40);
        set_mode(8'h41, FPEC_IDLE);
        set_mode(8'h42, FPEC_IDLE);
        // program one aligned unit
        wr(FPEC_OFS_TARGET, 32'h80);
        set_mode(8'h50, FPEC_WR_SETUP);
        set_mode(8'h51, FPEC_WRITING);
        `CHK(array_ctl.addr, 15'h0080);
        set_mode(8'h50, FPEC_WR_SETUP);
        set_mode(8'h54, FPEC_WR_CHK);
        set_mode(8'h40, FPEC_IDLE);
        // done interrupt: raise, mask, clear
        rd(FPEC_OFS_ISTAT, 32'h1);
        `CHK(irq, 1'b0);
        wr(FPEC_OFS_IMASK, 32'h1);
        settle();
        `CHK(irq, 1'b1);
        wr(FPEC_OFS_ISTAT, 32'h1);
        settle();
        `CHK(irq, 1'b0);
        // erase every block in turn
        for (int i = 0; i < FPEC_NBLK; i++) begin
            wr(FPEC_OFS_BLK, 32'(1 << i));
            wr(FPEC_OFS_TARGET, {17'h00000, base[i]});
            set_mode(8'h60, FPEC_CLR_SETUP);
            set_mode(8'h62, FPEC_CLEARING);
            `CHK(array_ctl.blocks, 5'(1 << i));
            set_mode(8'h60, FPEC_CLR_SETUP);
            set_mode(8'h48, FPEC_CLR_CHK);
            set_mode(8'h40, FPEC_IDLE);
        end
        wr(FPEC_OFS_BLK, 32'h3);
        rd(FPEC_OFS_BLK, 32'h0);
        wr(FPEC_OFS_BLK, 32'h10);
        set_mode(8'h00, FPEC_IDLE);
        rd(FPEC_OFS_BLK, 32'h0);
        // low-power entry
        subactive <= 1'b1;
        for (int n = 0; n < 10 && array_ctl.low_power !== 1'b1; n++) begin
            @(posedge clk_sys);
        end
        `CHK(array_ctl.low_power, 1'b1);
        wr(FPEC_OFS_PWR, 32'h80);
        settle();
        `CHK(array_ctl.low_power, 1'b0);
        subactive <= 1'b0;
        // misaligned program start
        wr(FPEC_OFS_TARGET, 32'h1001);
        set_mode(8'h7F, FPEC_IDLE);
        rd(FPEC_OFS_MODE, 32'h40);
        set_mode(8'h50, FPEC_WR_SETUP);
        set_mode(8'h51, FPEC_PROTECT);
        rd(FPEC_OFS_STAT, 32'h80);
        wr(FPEC_OFS_STAT, 32'h0);
        rd(FPEC_OFS_STAT, 32'h80);
        wr(FPEC_OFS_IMASK, 32'h2);
        settle();
        `CHK(irq, 1'b1);
        // second reset, then a reported failure during erase
        do_reset();
        `CHK(array_ctl.mode, FPEC_IDLE);
        `CHK(irq, 1'b0);
        wr(FPEC_OFS_GATE, 32'h80);
        rd(FPEC_OFS_STAT, 32'h0);
        set_mode(8'h40, FPEC_IDLE);
        wr(FPEC_OFS_BLK, 32'h1);
        wr(FPEC_OFS_TARGET, 32'h0);
        set_mode(8'h60, FPEC_CLR_SETUP);
        set_mode(8'h62, FPEC_CLEARING);
        op_fail <= 1'b1;
        for (int n = 0; n < 10 && array_ctl.mode !== FPEC_PROTECT; n++) begin
            @(posedge clk_sys);
        end
        `CHK(array_ctl.mode, FPEC_PROTECT);
        rd(FPEC_OFS_STAT, 32'h80);
        tally_and_finish();
    end
endmodule
`default_nettype wire
